// ### hdl/its_top.sv
// interrupt, event transfer and trap controller with an APB register file
// assumes the core takes branch and transfer orders and reports its level and trap return
//
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "its_defines.svh"
`default_nettype none

module its_top
  import its_pkg::*;
#(
  parameter int N_SRC = 20,
  parameter int N_EXT = 8,
  parameter int N_CH = 8
)(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [N_EXT-1:0] ext_irq_i,
  input wire logic [N_SRC-N_EXT-1:0] periph_irq_i,
  input wire logic [3:0] cpu_level_i,
  input wire logic trap_done_i,
  input wire logic nmi_i,
  input wire logic stack_access_i,
  input wire logic [15:0] sp_i,
  input wire logic [4:0] class_b_i,
  input wire logic sw_reset_i,
  input wire logic wdt_ovf_i,
  input wire logic swtrap_i,
  input wire logic [6:0] swtrap_num_i,
  output var its_branch_t branch_o,
  output var its_xfer_t xfer_o
);
  localparam int LAT_CHK = `ITS_LAT_MIN_CYC + 1;
  localparam logic [7:0] LAT_LOAD = 8'(`ITS_LAT_MIN_CYC - 1);

  // refuse sizes the decode and the vector table cannot serve
  if (N_SRC != 20 || N_EXT != 8 || N_CH != 8 || `ITS_LAT_MIN_CYC > `ITS_LAT_MAX_CYC)
    $error("its_top: unsupported size or latency");

  // fixed trap number of each source
  function automatic logic [6:0] src_trap(input logic [4:0] i);
    logic [6:0] t;
    t = 7'h00;
    if (i < 5'd8) t = 7'h18 + 7'(i);
    else if (i < 5'd14) t = 7'h22 + 7'(i - 5'd8);
    else if (i == 5'd14) t = 7'h2A;
    else if (i == 5'd15) t = 7'h47;
    else if (i == 5'd16) t = 7'h2B;
    else if (i == 5'd17) t = 7'h2C;
    else if (i == 5'd18) t = 7'h41;
    else t = 7'h43;
    return t;
  endfunction

  its_state_t state_q;
  its_tcls_t trap_cls_q;
  logic [7:0] lat_q;
  logic [N_SRC-1:0] src_req_q, src_en_q, src_route_q;
  logic [3:0] src_prio_q [N_SRC];
  logic [2:0] src_ch_q [N_SRC];
  logic [23:0] ch_src_q [N_CH];
  logic [23:0] ch_dst_q [N_CH];
  logic [7:0] ch_cnt_q [N_CH];
  logic [N_CH-1:0] ch_word_q, ch_incdst_q, ch_cont_q;
  logic [15:0] edge_sel_q;
  logic [7:0] tfr_q;
  logic [15:0] stku_q, stkl_q;
  logic rst_pend_q, sw_pend_q;
  logic [2:0] a_pend_q;
  logic b_pend_q;
  logic [6:0] sw_num_q;
  logic [3:0] cpu_acc_q;
  logic [N_EXT-1:0] ext_s1_q, ext_s2_q, ext_s3_q, ext_lvl_q;
  logic [N_EXT-1:0] ext_edge;
  logic [N_SRC-1:0] hw_set;
  logic best_ok, grant_ok, go_std, go_xfer, go_trap;
  logic [4:0] best_idx;
  logic [3:0] best_prio;
  logic [2:0] sel_ch;
  logic [7:0] sel_cnt;
  logic [23:0] sel_src;
  logic stk_ovf, stk_unf;
  logic wr_en, rd_en;
  logic [31:0] rdata;
  logic rd_err;

  // three-stage synchroniser, an edge counts when stages two and three agree
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ext_s1_q <= '0;
      ext_s2_q <= '0;
      ext_s3_q <= '0;
      ext_lvl_q <= '0;
    end
    else
    begin
      ext_s1_q <= ext_irq_i;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
      for (int i = 0; i < N_EXT; i++)
        if (ext_s2_q[i] == ext_s3_q[i]) ext_lvl_q[i] <= ext_s3_q[i];
    end
  end

  // edge select per input: bit0 rising, bit1 falling
  always_comb
  begin
    for (int i = 0; i < N_EXT; i++)
      ext_edge[i] = (ext_s2_q[i] == ext_s3_q[i]) && (ext_s3_q[i] != ext_lvl_q[i]) &&
        ((ext_s3_q[i] && edge_sel_q[2*i]) || (!ext_s3_q[i] && edge_sel_q[2*i+1]));
    hw_set = {periph_irq_i, ext_edge};
  end

  // arbitration over enabled pending sources, ties go to the lower index
  always_comb
  begin
    best_ok = 1'b0;
    best_idx = 5'd0;
    best_prio = 4'h0;
    for (int i = 0; i < N_SRC; i++)
      if (src_req_q[i] && src_en_q[i] && (!best_ok || src_prio_q[i] > best_prio))
      begin
        best_ok = 1'b1;
        best_idx = 5'(i);
        best_prio = src_prio_q[i];
      end
    sel_ch = src_ch_q[best_idx];
    sel_cnt = ch_cnt_q[sel_ch];
    sel_src = ch_src_q[sel_ch];
    grant_ok = best_ok && (best_prio > cpu_level_i) && (trap_cls_q == TC_NONE);
    go_trap = (state_q == ST_IDLE) && (rst_pend_q || a_pend_q != 3'b000 || b_pend_q || sw_pend_q);
    go_xfer = (state_q == ST_IDLE) && !go_trap && grant_ok && src_route_q[best_idx] &&
      (sel_cnt != 8'h00);
    go_std = (state_q == ST_IDLE) && !go_trap && grant_ok && !go_xfer;
  end

  // stack limit compare on each stack access
  assign stk_ovf = stack_access_i && (sp_i < stku_q);
  assign stk_unf = stack_access_i && (sp_i > stkl_q);

  // APB strobes: a write takes effect in the cycle pready is high, a read is sampled in the cycle before, while pready is low
  assign wr_en = psel_i && penable_i && pready_o && pwrite_i;
  assign rd_en = psel_i && penable_i && !pready_o;

  // trap pending bits, a new cause wins over being taken
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rst_pend_q <= 1'b1;
      a_pend_q <= 3'b000;
      b_pend_q <= 1'b0;
      sw_pend_q <= 1'b0;
      sw_num_q <= 7'h00;
    end
    else
    begin
      rst_pend_q <= sw_reset_i || wdt_ovf_i || (rst_pend_q && !go_trap);
      a_pend_q[0] <= nmi_i || (a_pend_q[0] && !(go_trap && !rst_pend_q &&
        trap_cls_q < TC_A));
      a_pend_q[1] <= stk_ovf || (a_pend_q[1] && !(go_trap && !rst_pend_q && !a_pend_q[0] &&
        trap_cls_q < TC_A));
      a_pend_q[2] <= stk_unf || (a_pend_q[2] && !(go_trap && !rst_pend_q && a_pend_q[1:0] == 2'b00 &&
        trap_cls_q < TC_A));
      b_pend_q <= (class_b_i != 5'b00000) || (b_pend_q && !(go_trap && !rst_pend_q &&
        a_pend_q == 3'b000 && trap_cls_q == TC_NONE));
      // a software trap arriving as the pending one is taken is kept, not lost
      if (go_trap && !rst_pend_q && a_pend_q == 3'b000 && !b_pend_q)
        sw_pend_q <= 1'b0;
      if (swtrap_i && (!sw_pend_q ||
        (go_trap && !rst_pend_q && a_pend_q == 3'b000 && !b_pend_q)))
      begin
        sw_pend_q <= 1'b1;
        sw_num_q <= swtrap_num_i;
      end
    end
  end

  // trap flag register, hardware set wins over software write-one-clear
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      tfr_q <= 8'h00;
    else
    begin
      for (int b = 0; b < 8; b++)
        if (wr_en && paddr_i == `ITS_TFR_OFS && pwdata_i[b]) tfr_q[b] <= 1'b0;
      if (nmi_i) tfr_q[`ITS_TF_NMI] <= 1'b1;
      if (stk_ovf) tfr_q[`ITS_TF_STACK_OVER_FLAG] <= 1'b1;
      if (stk_unf) tfr_q[`ITS_TF_STACK_UNDER_FLAG] <= 1'b1;
      for (int b = 0; b < 5; b++)
        if (class_b_i[b]) tfr_q[`ITS_TF_UNDEFINED_OPCODE_FLAG + b] <= 1'b1;
    end
  end

  // sequencer: choose trap or vectored service, wait the response time, issue branch
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_q <= ST_IDLE;
      trap_cls_q <= TC_NONE;
      lat_q <= 8'h00;
      branch_o <= '0;
      cpu_acc_q <= 4'h0;
    end
    else
    begin
      branch_o.valid <= 1'b0;
      if (trap_done_i && state_q == ST_IDLE) trap_cls_q <= TC_NONE;
      case (state_q)
        ST_IDLE:
        begin
          cpu_acc_q <= cpu_level_i;
          if (go_trap)
          begin
            state_q <= ST_LAT;
            lat_q <= LAT_LOAD;
            branch_o.is_trap <= 1'b1;
            branch_o.level <= cpu_level_i;
            if (rst_pend_q)
            begin
              trap_cls_q <= TC_RST;
              branch_o.vector <= `ITS_VEC_RESET;
            end
            else if (a_pend_q != 3'b000 && trap_cls_q < TC_A)
            begin
              trap_cls_q <= TC_A;
              branch_o.vector <= a_pend_q[0] ? `ITS_VEC_NMI :
                (a_pend_q[1] ? `ITS_VEC_STO : `ITS_VEC_STU);
            end
            else if (b_pend_q && trap_cls_q == TC_NONE)
            begin
              trap_cls_q <= TC_B;
              branch_o.vector <= `ITS_VEC_CLASSB;
            end
            else if (a_pend_q == 3'b000 && !b_pend_q)
              branch_o.vector <= {15'h0000, sw_num_q, 2'b00};
            else
              state_q <= ST_IDLE;
          end
          else if (go_std)
          begin
            state_q <= ST_LAT;
            lat_q <= LAT_LOAD;
            branch_o.is_trap <= 1'b0;
            branch_o.level <= best_prio;
            branch_o.vector <= {15'h0000, src_trap(best_idx), 2'b00};
          end
        end
        ST_LAT:
        begin
          if (lat_q == 8'h00)
          begin
            branch_o.valid <= 1'b1;
            state_q <= ST_IDLE;
          end
          else
            lat_q <= lat_q - 8'h01;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // source control registers; a hardware request wins over a software clear
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      src_req_q <= '0;
      src_en_q <= '0;
      src_route_q <= '0;
      edge_sel_q <= 16'h0000;
      stku_q <= `ITS_STKU_RST;
      stkl_q <= `ITS_STKL_RST;
      for (int i = 0; i < N_SRC; i++)
      begin
        src_prio_q[i] <= 4'h0;
        src_ch_q[i] <= 3'h0;
      end
    end
    else
    begin
      for (int i = 0; i < N_SRC; i++)
      begin
        if (wr_en && paddr_i == `ITS_SRC_BASE + 12'(4 * i))
        begin
          src_req_q[i] <= pwdata_i[`ITS_SC_REQ];
          src_en_q[i] <= pwdata_i[`ITS_SC_EN];
          src_prio_q[i] <= pwdata_i[`ITS_SC_PRIO +: 4];
          src_route_q[i] <= pwdata_i[`ITS_SC_ROUTE];
          src_ch_q[i] <= pwdata_i[`ITS_SC_CH +: 3];
        end
        else if ((go_std || (go_xfer && (ch_cont_q[sel_ch] || sel_cnt != 8'h01))) &&
          best_idx == 5'(i))
          src_req_q[i] <= 1'b0; // a transfer ending at zero keeps the request
        if (hw_set[i]) src_req_q[i] <= 1'b1;
      end
      if (wr_en)
      begin
        if (paddr_i == `ITS_EDGE_OFS) edge_sel_q <= pwdata_i[15:0];
        else if (paddr_i == `ITS_STKU_OFS) stku_q <= pwdata_i[15:0];
        else if (paddr_i == `ITS_STKL_OFS) stkl_q <= pwdata_i[15:0];
      end
    end
  end

  // event channels: software set-up and the one-cycle transfer
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      xfer_o <= '0;
      ch_word_q <= '0;
      ch_incdst_q <= '0;
      ch_cont_q <= '0;
      for (int c = 0; c < N_CH; c++)
      begin
        ch_src_q[c] <= 24'h000000;
        ch_dst_q[c] <= 24'h000000;
        ch_cnt_q[c] <= 8'h00;
      end
    end
    else
    begin
      xfer_o.valid <= go_xfer;
      if (go_xfer)
      begin
        xfer_o.word <= ch_word_q[sel_ch];
        xfer_o.src <= sel_src;
        xfer_o.dst <= ch_dst_q[sel_ch];
        if (ch_incdst_q[sel_ch])
          ch_dst_q[sel_ch] <= ch_dst_q[sel_ch] + (ch_word_q[sel_ch] ? 24'h000002 : 24'h000001);
        else
          ch_src_q[sel_ch] <= sel_src + (ch_word_q[sel_ch] ? 24'h000002 : 24'h000001);
        if (!ch_cont_q[sel_ch]) ch_cnt_q[sel_ch] <= sel_cnt - 8'h01;
      end
      for (int c = 0; c < N_CH; c++)
        if (wr_en && paddr_i[11:7] == 5'(`ITS_CH_BASE >> 7) && paddr_i[6:4] == 3'(c))
        begin
          if (paddr_i[3:0] == 4'h0) ch_src_q[c] <= pwdata_i[23:0];
          else if (paddr_i[3:0] == 4'h4) ch_dst_q[c] <= pwdata_i[23:0];
          else if (paddr_i[3:0] == 4'h8) ch_cnt_q[c] <= pwdata_i[7:0];
          else if (paddr_i[3:0] == 4'hC)
          begin
            ch_word_q[c] <= pwdata_i[`ITS_CC_WORD];
            ch_incdst_q[c] <= pwdata_i[`ITS_CC_INCDST];
            ch_cont_q[c] <= pwdata_i[`ITS_CC_CONT];
          end
        end
    end
  end

  // read decode, unmapped addresses answer with an error
  always_comb
  begin
    rdata = 32'h00000000;
    rd_err = 1'b0;
    if (paddr_i < `ITS_SRC_BASE + 12'(4 * N_SRC))
      rdata = {22'h000000, src_ch_q[paddr_i[6:2]], src_route_q[paddr_i[6:2]],
        src_prio_q[paddr_i[6:2]], src_en_q[paddr_i[6:2]], src_req_q[paddr_i[6:2]]};
    else if (paddr_i == `ITS_EDGE_OFS) rdata = {16'h0000, edge_sel_q};
    else if (paddr_i == `ITS_TFR_OFS) rdata = {24'h000000, tfr_q};
    else if (paddr_i == `ITS_STKU_OFS) rdata = {16'h0000, stku_q};
    else if (paddr_i == `ITS_STKL_OFS) rdata = {16'h0000, stkl_q};
    else if (paddr_i == `ITS_STAT_OFS) rdata = {29'h00000000, trap_cls_q, state_q};
    else if (paddr_i >= `ITS_CH_BASE && paddr_i < `ITS_CH_END && paddr_i[3:0] == 4'h0)
      rdata = {8'h00, ch_src_q[paddr_i[6:4]]};
    else if (paddr_i >= `ITS_CH_BASE && paddr_i < `ITS_CH_END && paddr_i[3:0] == 4'h4)
      rdata = {8'h00, ch_dst_q[paddr_i[6:4]]};
    else if (paddr_i >= `ITS_CH_BASE && paddr_i < `ITS_CH_END && paddr_i[3:0] == 4'h8)
      rdata = {24'h000000, ch_cnt_q[paddr_i[6:4]]};
    else if (paddr_i >= `ITS_CH_BASE && paddr_i < `ITS_CH_END && paddr_i[3:0] == 4'hC)
      rdata = {29'h00000000, ch_cont_q[paddr_i[6:4]], ch_incdst_q[paddr_i[6:4]],
        ch_word_q[paddr_i[6:4]]};
    else rd_err = 1'b1;
  end

  // APB answer: one wait state, ready and data from flip-flops
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pready_o <= 1'b0;
      prdata_o <= 32'h00000000;
      pslverr_o <= 1'b0;
    end
    else
    begin
      pready_o <= rd_en;
      pslverr_o <= rd_en && rd_err;
      if (rd_en && !pwrite_i) prdata_o <= rdata;
    end
  end

  // checks
  lat_window_a: assert property (@(posedge clock_i) disable iff (rst_i)
    go_std |-> ##LAT_CHK branch_o.valid) else $error("branch not issued at response time");
  xfer_no_branch_a: assert property (@(posedge clock_i) disable iff (rst_i)
    go_xfer |=> xfer_o.valid && state_q == ST_IDLE) else $error("transfer suspended program");
  ptr_step_a: assert property (@(posedge clock_i) disable iff (rst_i)
    go_xfer |=> xfer_o.src == $past(sel_src) && ($past(ch_incdst_q[sel_ch]) ||
    ch_src_q[$past(sel_ch)] == $past(sel_src) + ($past(ch_word_q[sel_ch]) ? 24'h000002 :
    24'h000001))) else $error("transfer source pointer wrong");
  cnt_down_a: assert property (@(posedge clock_i) disable iff (rst_i)
    go_xfer && !ch_cont_q[sel_ch] |=> ch_cnt_q[$past(sel_ch)] == $past(sel_cnt) - 8'h01)
    else $error("transfer counter not decremented");
  zero_irq_a: assert property (@(posedge clock_i) disable iff (rst_i)
    go_xfer && !ch_cont_q[sel_ch] && sel_cnt == 8'h01 |=> src_req_q[$past(best_idx)])
    else $error("request lost at zero count");
  higher_prio_a: assert property (@(posedge clock_i) disable iff (rst_i)
    $rose(branch_o.valid) && !branch_o.is_trap |-> branch_o.level > cpu_acc_q)
    else $error("service not strictly higher");
  stack_flag_a: assert property (@(posedge clock_i) disable iff (rst_i)
    stk_ovf |=> tfr_q[`ITS_TF_STACK_OVER_FLAG]) else $error("stack overflow flag not set");
  trap_guard_a: assert property (@(posedge clock_i) disable iff (rst_i)
    trap_cls_q != TC_NONE |-> !go_std && !go_xfer) else $error("interrupt cut into trap");
  nmi_vec_a: assert property (@(posedge clock_i) disable iff (rst_i)
    go_trap && !rst_pend_q && a_pend_q[0] && trap_cls_q < TC_A |-> ##LAT_CHK
    branch_o.valid && branch_o.vector == `ITS_VEC_NMI) else $error("nonmaskable vector wrong");
  xfer_seen_c: cover property (@(posedge clock_i) disable iff (rst_i) go_xfer);
  std_seen_c: cover property (@(posedge clock_i) disable iff (rst_i) go_std);
  trap_seen_c: cover property (@(posedge clock_i) disable iff (rst_i) go_trap && b_pend_q);

endmodule
`default_nettype wire

// ### hdl/its_defines.svh
// offsets, field positions, reset values and timing counts of the trap and interrupt block
// assumes a 12-bit APB byte address and a 100 MHz clock
`ifndef ITS_DEFINES_SVH
`define ITS_DEFINES_SVH

// register byte offsets
`define ITS_SRC_BASE 12'h000
`define ITS_EDGE_OFS 12'h080
`define ITS_TFR_OFS 12'h084
`define ITS_STKU_OFS 12'h088
`define ITS_STKL_OFS 12'h08C
`define ITS_STAT_OFS 12'h090
`define ITS_CH_BASE 12'h100
`define ITS_CH_END 12'h180

// source control fields
`define ITS_SC_REQ 0
`define ITS_SC_EN 1
`define ITS_SC_PRIO 2
`define ITS_SC_ROUTE 6
`define ITS_SC_CH 7

// channel control fields
`define ITS_CC_WORD 0
`define ITS_CC_INCDST 1
`define ITS_CC_CONT 2

// trap flag bit positions
`define ITS_TF_NMI 0
`define ITS_TF_STACK_OVER_FLAG 1
`define ITS_TF_STACK_UNDER_FLAG 2
`define ITS_TF_UNDEFINED_OPCODE_FLAG 3
`define ITS_TF_PROTECTED_INSTR_FAULT_FLAG 4
`define ITS_TF_ILLEGAL_OPERAND_FLAG 5
`define ITS_TF_ILLEGAL_FETCH_FLAG 6
`define ITS_TF_ILLEGAL_BUS_FLAG 7

// reset values
`define ITS_STKU_RST 16'h0000
`define ITS_STKL_RST 16'hFFFF

// trap vectors
`define ITS_VEC_RESET 24'h000000
`define ITS_VEC_NMI 24'h000008
`define ITS_VEC_STO 24'h000010
`define ITS_VEC_STU 24'h000018
`define ITS_VEC_CLASSB 24'h000028

// response time
`define ITS_CLK_NS 10
`define ITS_LAT_MIN_NS 250
`define ITS_LAT_MAX_NS 600
`define ITS_LAT_MIN_CYC ((`ITS_LAT_MIN_NS + `ITS_CLK_NS - 1) / `ITS_CLK_NS)
`define ITS_LAT_MAX_CYC (`ITS_LAT_MAX_NS / `ITS_CLK_NS)

`endif

// ### hdl/its_pkg.sv
// types shared by the trap and interrupt block
// assumes its_defines.svh supplies all numeric constants
`default_nettype none
package its_pkg;
  typedef enum logic {ST_IDLE = 1'b0, ST_LAT = 1'b1} its_state_t;
  typedef enum logic [1:0] {TC_NONE = 2'b00, TC_B = 2'b01, TC_A = 2'b10, TC_RST = 2'b11} its_tcls_t;
  typedef struct packed {
    logic valid;
    logic is_trap;
    logic [3:0] level;
    logic [23:0] vector;
  } its_branch_t;
  typedef struct packed {
    logic valid;
    logic word;
    logic [23:0] src;
    logic [23:0] dst;
  } its_xfer_t;
endpackage
`default_nettype wire

// ### verification/its_core_model.sv
// core model: obeys branch orders and ends each service after a fixed time
// assumes branch_i comes straight from its_top on the same clock
`timescale 1ns/1ns
`default_nettype none
module its_core_model
  import its_pkg::*;
#(
  parameter int SVC = 120,
  parameter int TRP = 30
)(
  input wire logic clock_i,
  input wire logic rst_i,
  input var its_branch_t branch_i,
  output logic [3:0] cpu_level_o,
  output logic trap_done_o
);
  int t_q;
  int tt_q;
  // interrupt service runs at the granted level, a nested return drops to 0
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cpu_level_o <= 4'h0;
      t_q <= 0;
    end
    else if (branch_i.valid && !branch_i.is_trap)
    begin
      cpu_level_o <= branch_i.level;
      t_q <= SVC;
    end
    else if (t_q == 1)
      cpu_level_o <= 4'h0;
    if (!rst_i && t_q > 0 && !(branch_i.valid && !branch_i.is_trap))
      t_q <= t_q - 1;
  end
  // trap service returns a fixed time after its branch
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tt_q <= 0;
      trap_done_o <= 1'b0;
    end
    else
    begin
      trap_done_o <= (tt_q == 1);
      if (branch_i.valid && branch_i.is_trap)
        tt_q <= TRP;
      else if (tt_q > 0)
        tt_q <= tt_q - 1;
    end
  end
endmodule
`default_nettype wire

// ### verification/its_top_tb.sv
// bench: APB tasks and table driven interrupt, transfer and trap tests
// assumes its_top beside its_core_model, one 100 MHz clock
`timescale 1ns/1ns
`include "its_defines.svh"
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin failures++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module its_top_tb
  import its_pkg::*;
;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic ps = 1'b0, pe = 1'b0, pw = 1'b0, swt = 1'b0, rdy, err, td, e;
  logic [11:0] pa = 12'h0, pi = 12'h0;
  logic [31:0] wd = 32'h0, rdat, q;
  logic [7:0] ext = 8'h0;
  logic [8:0] tv = 9'h0;
  logic [15:0] sp = 16'h0;
  logic [6:0] swn = 7'h0;
  logic [3:0] lvl;
  its_branch_t br, b;
  its_xfer_t xf, y;
  its_branch_t bq[$];
  its_xfer_t xq[$];
  int tq[$];
  int cyc = 0, failures = 0, n_compared = 0, t, t0;
  localparam logic [7:0] TN [20] = '{8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h1D, 8'h1E,
    8'h1F, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h2A, 8'h47, 8'h2B, 8'h2C, 8'h41, 8'h43};
  localparam logic [8:0] TP [10] = '{9'h041, 9'h001, 9'h002, 9'h004, 9'h008, 9'h010,
    9'h020, 9'h020, 9'h080, 9'h100};
  localparam logic [7:0] TF [10] = '{8'h09, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80, 8'h02,
    8'h04, 8'h00, 8'h00};
  localparam logic [23:0] TV [10] = '{24'h8, 24'h28, 24'h28, 24'h28, 24'h28, 24'h28,
    24'h10, 24'h18, 24'h0, 24'h0};
  its_top its_top_i (.clock_i(clock_i), .rst_i(rst_i), .psel_i(ps), .penable_i(pe),
    .pwrite_i(pw), .paddr_i(pa), .pwdata_i(wd), .prdata_o(rdat), .pready_o(rdy),
    .pslverr_o(err), .ext_irq_i(ext), .periph_irq_i(pi), .cpu_level_i(lvl),
    .trap_done_i(td), .nmi_i(tv[6]), .stack_access_i(tv[5]), .sp_i(sp),
    .class_b_i(tv[4:0]), .sw_reset_i(tv[7]), .wdt_ovf_i(tv[8]), .swtrap_i(swt),
    .swtrap_num_i(swn), .branch_o(br), .xfer_o(xf));
  its_core_model its_core_model_i (.clock_i(clock_i), .rst_i(rst_i), .branch_i(br),
    .cpu_level_o(lvl), .trap_done_o(td));
  always #5 clock_i = ~clock_i;
  // records branch orders with their cycle number, and transfer orders without one
  always @(posedge clock_i)
  begin
    cyc <= cyc + 1;
    if (br.valid === 1'b1)
    begin
      bq.push_back(br);
      tq.push_back(cyc);
    end
    if (xf.valid === 1'b1)
      xq.push_back(xf);
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock_i);
    ps <= 1'b1;
    pw <= w;
    pa <= a;
    wd <= d;
    @(posedge clock_i);
    pe <= 1'b1;
    @(posedge clock_i);
    while (rdy !== 1'b1)
      @(posedge clock_i);
    q = rdat;
    e = err;
    ps <= 1'b0;
    pe <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    `CHK(q, x)
  endtask
  // one request: ext input toggles, peripheral line pulses
  task automatic fire(input int k);
    @(posedge clock_i);
    if (k < 8)
      ext[k] <= ~ext[k];
    else
      pi[k-8] <= 1'b1;
    t0 = cyc;
    @(posedge clock_i);
    pi <= 12'h0;
  endtask
  task automatic get_br(input logic [23:0] v, input logic [3:0] l, input logic tr);
    int n;
    n = 0;
    while (bq.size() == 0 && n < 3000)
    begin
      @(posedge clock_i);
      n++;
    end
    if (bq.size() == 0) failures++;
    b = (bq.size() != 0) ? bq.pop_front() : '0;
    t = (tq.size() != 0) ? tq.pop_front() : 0;
    `CHK(b.vector, v)
    `CHK(b.is_trap, tr)
    if (l !== 4'hF)
      `CHK(b.level, l)
  endtask
  task automatic get_xf(input its_xfer_t x);
    int n;
    n = 0;
    while (xq.size() == 0 && n < 100)
    begin
      @(posedge clock_i);
      n++;
    end
    repeat (2) @(posedge clock_i);
    `CHK(xq.size(), 1)
    y = (xq.size() != 0) ? xq.pop_front() : '0;
    `CHK(y, x)
    `CHK(bq.size(), 0)
  endtask
  // waits for the sequencer and the core level to settle
  task automatic idle();
    int n;
    n = 0;
    do
    begin
      apb(1'b0, `ITS_STAT_OFS, 32'h0);
      n++;
    end
    while ((q !== 32'h0 || lvl !== 4'h0) && n < 200);
    if (q !== 32'h0 || lvl !== 4'h0) failures++;
  endtask
  task automatic test_done();
    if (failures == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    #400000;
    failures++;
    test_done();
  end
  // main sequence
  initial
  begin
    repeat (4) @(posedge clock_i);
    rst_i <= 1'b0;
    t0 = cyc;
    get_br(`ITS_VEC_RESET, 4'hF, 1'b1);
    `CHK((t - t0) inside {[25:60]}, 1'b1)
    rd(`ITS_STKU_OFS, {16'h0, `ITS_STKU_RST});
    rd(`ITS_STKL_OFS, {16'h0, `ITS_STKL_RST});
    apb(1'b0, 12'h094, 32'h0);
    `CHK(e, 1'b1)
    idle();
    apb(1'b1, `ITS_EDGE_OFS, 32'h5555);
    for (int k = 0; k < 20; k++)
    begin
      apb(1'b1, 12'(4 * k), 32'((k % 14 + 1) * 4 + 2));
      fire(k);
      get_br({14'h0, TN[k], 2'b00}, 4'(k % 14 + 1), 1'b0);
      `CHK((t - t0) inside {[25:60]}, 1'b1)
      rd(12'(4 * k), 32'((k % 14 + 1) * 4 + 2));
      idle();
    end
    apb(1'b1, `ITS_SRC_BASE, 32'h0);
    for (int m = 1; m < 4; m++)
    begin
      apb(1'b1, `ITS_EDGE_OFS, 32'(m));
      fire(0);
      repeat (6) @(posedge clock_i);
      rd(`ITS_SRC_BASE, 32'(m >> 1));
      apb(1'b1, `ITS_SRC_BASE, 32'h0);
      fire(0);
      repeat (6) @(posedge clock_i);
      rd(`ITS_SRC_BASE, 32'(m & 1));
      apb(1'b1, `ITS_SRC_BASE, 32'h0);
    end
    apb(1'b1, 12'h020, 32'h16);
    apb(1'b1, 12'h024, 32'h16);
    apb(1'b1, 12'h028, 32'h1A);
    fire(8);
    get_br(24'h88, 4'h5, 1'b0);
    @(posedge clock_i);
    swt <= 1'b1;
    swn <= 7'h7F;
    @(posedge clock_i);
    swt <= 1'b0;
    get_br(24'h1FC, 4'h5, 1'b1);
    fire(9);
    fire(10);
    get_br(24'h90, 4'h6, 1'b0);
    get_br(24'h8C, 4'h5, 1'b0);
    idle();
    apb(1'b1, 12'h02C, 32'h0E);
    apb(1'b1, 12'h030, 32'h26);
    @(posedge clock_i);
    pi <= 12'h018;
    @(posedge clock_i);
    pi <= 12'h0;
    get_br(24'h98, 4'h9, 1'b0);
    get_br(24'h94, 4'h3, 1'b0);
    idle();
    apb(1'b1, 12'h170, 32'h1000);
    apb(1'b1, 12'h174, 32'h2000);
    apb(1'b1, 12'h178, 32'h2);
    apb(1'b1, 12'h17C, 32'h3);
    apb(1'b1, 12'h034, 32'h3D2);
    for (int i = 0; i < 2; i++)
    begin
      fire(13);
      get_xf({2'b11, 24'h1000, 24'(24'h2000 + 2 * i)});
    end
    rd(12'h178, 32'h0);
    get_br(24'h9C, 4'h4, 1'b0);
    idle();
    apb(1'b1, 12'h100, 32'h10);
    apb(1'b1, 12'h104, 32'h0);
    apb(1'b1, 12'h108, 32'h1);
    apb(1'b1, 12'h10C, 32'h4);
    apb(1'b1, 12'h038, 32'h52);
    for (int i = 0; i < 2; i++)
    begin
      fire(14);
      get_xf({2'b10, 24'(24'h10 + i), 24'h0});
    end
    rd(12'h108, 32'h1);
    apb(1'b1, `ITS_STKU_OFS, 32'h100);
    apb(1'b1, `ITS_STKL_OFS, 32'h200);
    for (int j = 0; j < 10; j++)
    begin
      @(posedge clock_i);
      sp <= (j == 7) ? 16'h0201 : 16'h00FF;
      tv <= TP[j];
      @(posedge clock_i);
      tv <= 9'h0;
      get_br(TV[j], 4'hF, 1'b1);
      if (j == 0)
        get_br(`ITS_VEC_CLASSB, 4'hF, 1'b1);
      idle();
      rd(`ITS_TFR_OFS, {24'h0, TF[j]});
      apb(1'b1, `ITS_TFR_OFS, 32'hFF);
    end
    test_done();
  end
endmodule
`default_nettype wire
